//--- design/ufmc_cfg.svh
`ifndef UFMC_CFG_SVH
`define UFMC_CFG_SVH
// Summary of operation
// - receive polarity invert set means the receive line idles low, else idles high.
// - high-speed select gives 4 ticks per bit, cleared gives 16 ticks per bit.
// - format 00 8-bit none, 01 8-bit even, 10 8-bit odd, 11 9-bit none.
// - stop count select set ends each frame with two stop bits, else one.
// - auto rate bit measures the next 55h sync character, then clears itself.
// - auto rate measurement only starts while high-speed select is cleared.

`define UFMC_OFF_MODE    8'h00
`define UFMC_OFF_DIV     8'h04
`define UFMC_OFF_TXD     8'h08
`define UFMC_OFF_RXD     8'h0C
`define UFMC_OFF_STAT    8'h10

`define UFMC_MODE_RST    6'h00
`define UFMC_DIV_RST     16'h0000
`define UFMC_FIFO_DEPTH  8

`define UFMC_TICKS_HS_M1  4'h3
`define UFMC_TICKS_STD_M1 4'hF
`define UFMC_HALF_HS_M1   4'h1
`define UFMC_HALF_STD_M1  4'h7

`define UFMC_BITS8_M1    4'h7
`define UFMC_BITS9_M1    4'h8

`define UFMC_FMT_8E      2'h1
`define UFMC_FMT_8O      2'h2
`define UFMC_FMT_9N      2'h3

`define UFMC_AB_SHIFT    7
`define UFMC_AB_EDGES_M1 3'h3

`define UFMC_STAT_PERR   3
`define UFMC_STAT_FERR   4

`define UFMC_RESP_OKAY   2'h0
`define UFMC_RESP_SLVERR 2'h2
`endif

//--- design/ufmc_fifo.sv
`timescale 1ns/1ps
module ufmc_fifo #(
	parameter int W = 11,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem_reg [D];
	logic [W-1:0]  mem_next [D];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	always_comb begin
		in_ready  = (cnt_reg != (AW+1)'(D));
		out_valid = (cnt_reg != '0);
		out_data  = mem_reg[rd_reg];
		push      = in_valid & in_ready;
		pop       = out_valid & out_ready;
		mem_next  = mem_reg;
		wr_next   = wr_reg;
		rd_next   = rd_reg;
		if (push) begin
			mem_next[wr_reg] = in_data;
			wr_next = (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
		end
		cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk) begin
		mem_reg <= mem_next;
		if (!rst_b) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

//--- design/ufmc_pkg.sv
package ufmc_pkg;
	typedef struct packed {
		logic       auto_rate_measure_enable;
		logic       rx_polarity_invert;
		logic       high_speed_rate_select;
		logic [1:0] frame_format_select;
		logic       stop_count_select;
	} ufmc_mode_type;

	typedef struct packed {
		logic       ab_busy;
		logic       frm_err;
		logic       par_err;
		logic       fifo_full;
		logic       tx_busy;
		logic       rx_avail;
	} ufmc_status_type;

	typedef struct packed {
		logic       par_err;
		logic       frm_err;
		logic [8:0] data;
	} ufmc_rxchar_type;

	typedef enum logic [3:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD,
		RX_AB_WAIT, RX_AB_MEAS, RX_AB_TAIL
	} ufmc_rx_state_type;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
	} ufmc_tx_state_type;
endpackage

//--- design/ufmc_top.sv
`timescale 1ns/1ps
`include "ufmc_cfg.svh"
module ufmc_top
	import ufmc_pkg::*;
#(
	parameter int DIV_W = 16,
	parameter int DEPTH = `UFMC_FIFO_DEPTH
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        SERIAL_RECEIVE_LINE,
	output logic             SERIAL_TRANSMIT_LINE
);
	localparam int ABW = DIV_W + `UFMC_AB_SHIFT;

	// register file and bus state
	ufmc_mode_type      mode_reg, mode_next;
	logic [DIV_W-1:0]   div_reg, div_next;
	logic               perr_reg, perr_next, ferr_reg, ferr_next;
	logic               awh_reg, awh_next, wh_reg, wh_next;
	logic [7:0]         awaddr_reg, awaddr_next;
	logic [31:0]        wdata_reg, wdata_next;
	logic [3:0]         wstrb_reg, wstrb_next;
	logic               bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]         bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0]        rdata_reg, rdata_next, wmerge;
	logic               do_wr, do_rd, fifo_pop;
	ufmc_status_type    stat;

	// rate generator
	logic [DIV_W-1:0]   dcnt_reg, dcnt_next;
	logic               baud_tick;
	logic [3:0]         ticks_m1, half_m1, nbits_m1;
	logic               has_par, par_odd, nine;

	// receiver
	ufmc_rx_state_type  rx_st_reg, rx_st_next;
	logic [3:0]         rx_ph_reg, rx_ph_next, rx_cnt_reg, rx_cnt_next;
	logic [8:0]         rx_sh_reg, rx_sh_next;
	logic               rx_pe_reg, rx_pe_next, rx_fe_reg, rx_fe_next;
	logic               rx_prev_reg, rx_prev_next;
	logic [ABW-1:0]     ab_cnt_reg, ab_cnt_next, ab_span;
	logic [2:0]         ab_edg_reg, ab_edg_next;
	logic [DIV_W-1:0]   ab_q, ab_div;
	logic               rx_bit, rx_fall, rx_hit, ab_done, push_fire;
	ufmc_rxchar_type    rx_char, fifo_out;
	logic               fifo_in_ready, fifo_out_valid;

	// transmitter
	ufmc_tx_state_type  tx_st_reg, tx_st_next;
	logic [3:0]         tx_ph_reg, tx_ph_next, tx_cnt_reg, tx_cnt_next;
	logic [8:0]         tx_sh_reg, tx_sh_next;
	logic               tx_par_reg, tx_par_next, tx_line_reg, tx_line_next;
	logic               tx_hit, tx_load;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	ufmc_fifo #(
		.W ($bits(ufmc_rxchar_type)),
		.D (DEPTH)
	) u_rx_fifo (
		.clk       (CORE_CLK),
		.rst_b     (RST_B),
		.in_valid  (rx_st_reg == RX_HOLD),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_char),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out)
	);

	assign S_AXI_AWREADY        = !awh_reg;
	assign S_AXI_WREADY         = !wh_reg;
	assign S_AXI_BVALID         = bvalid_reg;
	assign S_AXI_BRESP          = bresp_reg;
	assign S_AXI_ARREADY        = !rvalid_reg;
	assign S_AXI_RVALID         = rvalid_reg;
	assign S_AXI_RDATA          = rdata_reg;
	assign S_AXI_RRESP          = rresp_reg;
	assign SERIAL_TRANSMIT_LINE = tx_line_reg;

	always_comb begin
		do_wr       = awh_reg & wh_reg & !bvalid_reg;
		do_rd       = S_AXI_ARVALID & !rvalid_reg;
		fifo_pop    = do_rd & (S_AXI_ARADDR == `UFMC_OFF_RXD) & fifo_out_valid;
		push_fire   = (rx_st_reg == RX_HOLD) & fifo_in_ready;
		stat        = '{ab_busy:   (rx_st_reg == RX_AB_WAIT) | (rx_st_reg == RX_AB_MEAS),
			frm_err: ferr_reg, par_err: perr_reg, fifo_full: !fifo_in_ready,
			tx_busy: tx_st_reg != TX_IDLE, rx_avail: fifo_out_valid};
		wmerge      = 32'h0000_0000;
		awh_next    = awh_reg | S_AXI_AWVALID;
		wh_next     = wh_reg | S_AXI_WVALID;
		awaddr_next = awh_reg ? awaddr_reg : S_AXI_AWADDR;
		wdata_next  = wh_reg ? wdata_reg : S_AXI_WDATA;
		wstrb_next  = wh_reg ? wstrb_reg : S_AXI_WSTRB;
		bvalid_next = bvalid_reg & !S_AXI_BREADY;
		bresp_next  = bresp_reg;
		rvalid_next = rvalid_reg & !S_AXI_RREADY;
		rresp_next  = rresp_reg;
		rdata_next  = rdata_reg;
		mode_next   = mode_reg;
		div_next    = div_reg;
		perr_next   = perr_reg;
		ferr_next   = ferr_reg;
		if (ab_done) begin
			mode_next.auto_rate_measure_enable = 1'b0;
			div_next = ab_div;
		end
		if (do_wr) begin
			awh_next    = 1'b0;
			wh_next     = 1'b0;
			bvalid_next = 1'b1;
			bresp_next  = `UFMC_RESP_OKAY;
			case (awaddr_reg)
				`UFMC_OFF_MODE: begin
					wmerge    = merge(32'(mode_reg), wdata_reg, wstrb_reg);
					mode_next = ufmc_mode_type'(wmerge[$bits(ufmc_mode_type)-1:0]);
				end
				`UFMC_OFF_DIV: begin
					wmerge   = merge(32'(div_reg), wdata_reg, wstrb_reg);
					div_next = wmerge[DIV_W-1:0];
				end
				`UFMC_OFF_TXD: ;
				`UFMC_OFF_STAT: begin
					perr_next = perr_reg & !(wstrb_reg[0] & wdata_reg[`UFMC_STAT_PERR]);
					ferr_next = ferr_reg & !(wstrb_reg[0] & wdata_reg[`UFMC_STAT_FERR]);
				end
				default: bresp_next = `UFMC_RESP_SLVERR;
			endcase
		end
		// a fresh error beats a write-one-to-clear in the same cycle
		perr_next = perr_next | (push_fire & rx_pe_reg);
		ferr_next = ferr_next | (push_fire & rx_fe_reg);
		if (do_rd) begin
			rvalid_next = 1'b1;
			rresp_next  = `UFMC_RESP_OKAY;
			case (S_AXI_ARADDR)
				`UFMC_OFF_MODE: rdata_next = 32'(mode_reg);
				`UFMC_OFF_DIV:  rdata_next = 32'(div_reg);
				`UFMC_OFF_TXD:  rdata_next = 32'h0000_0000;
				`UFMC_OFF_RXD:  rdata_next = {16'h0000, fifo_out_valid, 4'h0, fifo_out};
				`UFMC_OFF_STAT: rdata_next = 32'(stat);
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = `UFMC_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			mode_reg   <= `UFMC_MODE_RST;
			div_reg    <= `UFMC_DIV_RST;
			perr_reg   <= 1'b0;
			ferr_reg   <= 1'b0;
			awh_reg    <= 1'b0;
			wh_reg     <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= `UFMC_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg  <= `UFMC_RESP_OKAY;
			rdata_reg  <= '0;
		end else begin
			mode_reg   <= mode_next;
			div_reg    <= div_next;
			perr_reg   <= perr_next;
			ferr_reg   <= ferr_next;
			awh_reg    <= awh_next;
			wh_reg     <= wh_next;
			awaddr_reg <= awaddr_next;
			wdata_reg  <= wdata_next;
			wstrb_reg  <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg  <= rresp_next;
			rdata_reg  <= rdata_next;
		end
	end

	always_comb begin
		baud_tick = (dcnt_reg >= div_reg);
		dcnt_next = baud_tick ? '0 : dcnt_reg + 1'b1;
		ticks_m1  = mode_reg.high_speed_rate_select ? `UFMC_TICKS_HS_M1 : `UFMC_TICKS_STD_M1;
		half_m1   = mode_reg.high_speed_rate_select ? `UFMC_HALF_HS_M1 : `UFMC_HALF_STD_M1;
		nine      = (mode_reg.frame_format_select == `UFMC_FMT_9N);
		nbits_m1  = nine ? `UFMC_BITS9_M1 : `UFMC_BITS8_M1;
		par_odd   = (mode_reg.frame_format_select == `UFMC_FMT_8O);
		has_par   = par_odd | (mode_reg.frame_format_select == `UFMC_FMT_8E);
	end

	always_comb begin
		rx_bit       = SERIAL_RECEIVE_LINE ^ mode_reg.rx_polarity_invert;
		rx_fall      = rx_prev_reg & !rx_bit;
		rx_hit       = baud_tick & (rx_ph_reg == ticks_m1);
		ab_span      = ab_cnt_reg + ABW'(~&ab_cnt_reg);
		ab_q         = ab_span[ABW-1 -: DIV_W];
		ab_div       = (ab_q == '0) ? '0 : ab_q - 1'b1;
		ab_done      = (rx_st_reg == RX_AB_MEAS) & rx_fall & (ab_edg_reg == `UFMC_AB_EDGES_M1);
		rx_char      = '{par_err: rx_pe_reg, frm_err: rx_fe_reg,
			data: nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]}};
		rx_st_next   = rx_st_reg;
		rx_ph_next   = rx_ph_reg;
		rx_cnt_next  = rx_cnt_reg;
		rx_sh_next   = rx_sh_reg;
		rx_pe_next   = rx_pe_reg;
		rx_fe_next   = rx_fe_reg;
		rx_prev_next = rx_bit;
		ab_cnt_next  = ab_cnt_reg;
		ab_edg_next  = ab_edg_reg;
		if (baud_tick) begin
			rx_ph_next = rx_hit ? '0 : rx_ph_reg + 1'b1;
		end
		case (rx_st_reg)
			RX_IDLE: begin
				rx_ph_next = '0;
				if (mode_reg.auto_rate_measure_enable & !mode_reg.high_speed_rate_select) begin
					rx_st_next = RX_AB_WAIT;
				end else if (!rx_bit) begin
					rx_st_next = RX_START;
				end
			end
			RX_START: begin
				if (baud_tick & (rx_ph_reg == half_m1)) begin
					rx_ph_next  = '0;
					rx_cnt_next = '0;
					rx_pe_next  = 1'b0;
					rx_fe_next  = 1'b0;
					rx_st_next  = rx_bit ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_hit) begin
					rx_sh_next  = {rx_bit, rx_sh_reg[8:1]};
					rx_cnt_next = rx_cnt_reg + 1'b1;
					if (rx_cnt_reg == nbits_m1) begin
						rx_cnt_next = '0;
						rx_st_next  = has_par ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (rx_hit) begin
					rx_pe_next = rx_bit ^ (^rx_sh_reg[8:1]) ^ par_odd;
					rx_st_next = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_hit) begin
					rx_fe_next  = rx_fe_reg | !rx_bit;
					rx_cnt_next = rx_cnt_reg + 1'b1;
					if (!mode_reg.stop_count_select | (rx_cnt_reg != '0)) begin
						rx_st_next = RX_HOLD;
					end
				end
			end
			// the line is not watched while a character waits for room
			RX_HOLD: if (fifo_in_ready) begin
				rx_st_next = RX_IDLE;
			end
			RX_AB_WAIT: begin
				if (!mode_reg.auto_rate_measure_enable) begin
					rx_st_next = RX_IDLE;
				end else if (rx_fall) begin
					ab_cnt_next = '0;
					ab_edg_next = '0;
					rx_st_next  = RX_AB_MEAS;
				end
			end
			RX_AB_MEAS: begin
				ab_cnt_next = ab_span;
				if (rx_fall) begin
					ab_edg_next = ab_edg_reg + 1'b1;
					if (ab_done) begin
						rx_st_next = RX_AB_TAIL;
					end
				end
			end
			RX_AB_TAIL: if (rx_bit) begin
				rx_st_next = RX_IDLE;
			end
			default: rx_st_next = RX_IDLE;
		endcase
	end

	always_comb begin
		tx_hit       = baud_tick & (tx_ph_reg == ticks_m1);
		tx_load      = do_wr & (awaddr_reg == `UFMC_OFF_TXD) & wstrb_reg[0] & (tx_st_reg == TX_IDLE);
		tx_st_next   = tx_st_reg;
		tx_ph_next   = tx_ph_reg;
		tx_cnt_next  = tx_cnt_reg;
		tx_sh_next   = tx_sh_reg;
		tx_par_next  = tx_par_reg;
		tx_line_next = tx_line_reg;
		if (baud_tick & (tx_st_reg != TX_IDLE)) begin
			tx_ph_next = tx_hit ? '0 : tx_ph_reg + 1'b1;
		end
		case (tx_st_reg)
			TX_IDLE: begin
				tx_line_next = 1'b1;
				if (tx_load) begin
					tx_sh_next   = {wdata_reg[8] & nine, wdata_reg[7:0]};
					tx_par_next  = (^wdata_reg[7:0]) ^ par_odd;
					tx_ph_next   = '0;
					tx_line_next = 1'b0;
					tx_st_next   = TX_START;
				end
			end
			TX_START: if (tx_hit) begin
				tx_line_next = tx_sh_reg[0];
				tx_sh_next   = {1'b0, tx_sh_reg[8:1]};
				tx_cnt_next  = '0;
				tx_st_next   = TX_DATA;
			end
			TX_DATA: if (tx_hit) begin
				tx_line_next = tx_sh_reg[0];
				tx_sh_next   = {1'b0, tx_sh_reg[8:1]};
				tx_cnt_next  = tx_cnt_reg + 1'b1;
				if (tx_cnt_reg == nbits_m1) begin
					tx_cnt_next  = '0;
					tx_line_next = has_par ? tx_par_reg : 1'b1;
					tx_st_next   = has_par ? TX_PAR : TX_STOP;
				end
			end
			TX_PAR: if (tx_hit) begin
				tx_line_next = 1'b1;
				tx_st_next   = TX_STOP;
			end
			TX_STOP: if (tx_hit) begin
				tx_cnt_next = tx_cnt_reg + 1'b1;
				if (!mode_reg.stop_count_select | (tx_cnt_reg != '0)) begin
					tx_st_next = TX_IDLE;
				end
			end
			default: tx_st_next = TX_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			dcnt_reg    <= '0;
			rx_st_reg   <= RX_IDLE;
			rx_ph_reg   <= '0;
			rx_cnt_reg  <= '0;
			rx_sh_reg   <= '0;
			rx_pe_reg   <= 1'b0;
			rx_fe_reg   <= 1'b0;
			rx_prev_reg <= 1'b1;
			ab_cnt_reg  <= '0;
			ab_edg_reg  <= '0;
			tx_st_reg   <= TX_IDLE;
			tx_ph_reg   <= '0;
			tx_cnt_reg  <= '0;
			tx_sh_reg   <= '0;
			tx_par_reg  <= 1'b0;
			tx_line_reg <= 1'b1;
		end else begin
			dcnt_reg    <= dcnt_next;
			rx_st_reg   <= rx_st_next;
			rx_ph_reg   <= rx_ph_next;
			rx_cnt_reg  <= rx_cnt_next;
			rx_sh_reg   <= rx_sh_next;
			rx_pe_reg   <= rx_pe_next;
			rx_fe_reg   <= rx_fe_next;
			rx_prev_reg <= rx_prev_next;
			ab_cnt_reg  <= ab_cnt_next;
			ab_edg_reg  <= ab_edg_next;
			tx_st_reg   <= tx_st_next;
			tx_ph_reg   <= tx_ph_next;
			tx_cnt_reg  <= tx_cnt_next;
			tx_sh_reg   <= tx_sh_next;
			tx_par_reg  <= tx_par_next;
			tx_line_reg <= tx_line_next;
		end
	end

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	AST_RX_IDLE_LEVEL: assert property ((rx_st_reg == RX_IDLE) && !mode_reg.auto_rate_measure_enable
		&& (SERIAL_RECEIVE_LINE == !mode_reg.rx_polarity_invert) |=> rx_st_reg == RX_IDLE)
		else $error("receiver left idle on idle line level");
	AST_TX_TICKS: assert property ((tx_st_reg != TX_IDLE) && baud_tick
		&& (tx_ph_reg == (mode_reg.high_speed_rate_select ? `UFMC_TICKS_HS_M1
		: `UFMC_TICKS_STD_M1)) |=> tx_ph_reg == '0)
		else $error("bit period tick count wrong");
	AST_RX_DATA_LEN: assert property ((rx_st_reg == RX_DATA) && rx_hit && (rx_cnt_reg == nbits_m1)
		|=> rx_st_reg == ($past(has_par) ? RX_PAR : RX_STOP))
		else $error("data bit count does not match format");
	AST_TX_TWO_STOP: assert property ((tx_st_reg == TX_STOP) && tx_hit && (tx_cnt_reg == 4'h0)
		&& mode_reg.stop_count_select |=> (tx_st_reg == TX_STOP) && tx_line_reg)
		else $error("second stop bit missing");
	AST_AB_CLEAR: assert property (ab_done && !do_wr |=> !mode_reg.auto_rate_measure_enable)
		else $error("auto rate bit not cleared on completion");
	AST_AB_STD_ONLY: assert property ((rx_st_reg == RX_IDLE) && mode_reg.high_speed_rate_select
		|=> (rx_st_reg != RX_AB_WAIT) && (rx_st_reg != RX_AB_MEAS))
		else $error("auto rate measure started in high speed mode");
	AST_AB_LOAD: assert property (ab_done && !do_wr |=> div_reg == $past(ab_div))
		else $error("measured divisor not loaded");
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped before accepted");

	COV_AB_DONE: cover property (ab_done);
	COV_FIFO_FULL: cover property (push_fire ##1 !fifo_in_ready);
	COV_TX_PAR: cover property (tx_st_reg == TX_PAR ##[1:400] tx_st_reg == TX_IDLE);
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "ufmc_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	logic        clk, rst_b, rx_line, tx_line;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          mismatches = 0;
	int          compares = 0;
	int          cycles = 0;
	ufmc_top dut_u (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .SERIAL_RECEIVE_LINE(rx_line), .SERIAL_TRANSMIT_LINE(tx_line));
	ufmc_remote remote_u (.clk(clk), .line_out(rx_line), .line_in(tx_line));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ceiling well above the few thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			end_of_test();
		end
	end
	// ready and valid are registered, so the falling edge shows what the next edge takes
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit pa, pw, pb, ha, hw, hb;
		pa = 1;
		pw = 1;
		pb = 1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw || pb) begin
			@(negedge clk);
			ha = pa && awready;
			hw = pw && wready;
			hb = pb && bvalid;
			if (hb) r = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
			pa = pa && !ha;
			pw = pw && !hw;
			pb = pb && !hb;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit pa, pr, ha, hr;
		pa = 1;
		pr = 1;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (pa || pr) begin
			@(negedge clk);
			ha = pa && arready;
			hr = pr && rvalid;
			if (hr) d = rdata;
			if (hr) r = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
			pa = pa && !ha;
			pr = pr && !hr;
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(d, e)
	endtask
	task automatic flush();
		logic [31:0] d;
		logic [1:0] r;
		repeat (9) rd(`UFMC_OFF_RXD, d, r);
	endtask
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rchk(`UFMC_OFF_MODE, 32'h0000_0000);
		rchk(`UFMC_OFF_DIV, 32'h0000_0000);
		w(`UFMC_OFF_DIV, 32'h0000_1234);
		rchk(`UFMC_OFF_DIV, 32'h0000_1234);
		w(`UFMC_OFF_DIV, 32'h0000_0000);
		rd(8'h14, d, r);
		`CHK(r, `UFMC_RESP_SLVERR)
		wr(8'h18, 32'h0000_FFFF, r);
		`CHK(r, `UFMC_RESP_SLVERR)
		$display("test regs done");
	endtask
	task automatic t_rx_formats();
		for (int f = 0; f < 4; f++) begin
			w(`UFMC_OFF_MODE, f << 1);
			remote_u.send(9'h1A5, f == 3 ? 9 : 8, f == 3 ? 0 : f, 1, 16, 0, 0);
			rchk(`UFMC_OFF_RXD, f == 3 ? 32'h0000_81A5 : 32'h0000_80A5);
			if (f == 1 || f == 2) begin
				remote_u.send(9'h1A5, 8, 3 - f, 1, 16, 0, 0);
				rchk(`UFMC_OFF_RXD, 32'h0000_84A5);
			end
		end
		// one stop bit would miss the low second stop
		w(`UFMC_OFF_MODE, 32'h0000_0001);
		remote_u.send(9'h0A5, 8, 0, 2, 16, 0, 1);
		rchk(`UFMC_OFF_RXD, 32'h0000_82A5);
		// both sticky errors were provoked above; write one to clear them
		rchk(`UFMC_OFF_STAT, 32'h0000_0018);
		w(`UFMC_OFF_STAT, 32'h0000_0018);
		rchk(`UFMC_OFF_STAT, 32'h0000_0000);
		$display("test rx formats done");
	endtask
	task automatic t_tx();
		logic [8:0] d;
		logic p, st;
		logic [31:0] s;
		logic [1:0] r;
		for (int f = 0; f < 4; f++) begin
			w(`UFMC_OFF_MODE, (f << 1) | (f == 3));
			fork
				remote_u.recv(f == 3 ? 9 : 8, f == 3 ? 0 : f, f == 3 ? 2 : 1, 16, d, p, st);
				w(`UFMC_OFF_TXD, 32'h0000_01A5);
			join
			`CHK(d, f == 3 ? 9'h1A5 : 9'h0A5)
			`CHK(p, 1'(f == 2))
			`CHK(st, 1'b1)
			// mid second stop: half a bit still owed, one stop would already be idle
			if (f == 3) begin
				rd(`UFMC_OFF_STAT, s, r);
				`CHK(s[1], 1'b1)
			end
			repeat (40) @(posedge clk);
		end
		$display("test tx done");
	endtask
	task automatic t_polarity();
		logic [31:0] d;
		logic [1:0] r;
		w(`UFMC_OFF_MODE, 32'h0000_0010);
		remote_u.idle(1);
		repeat (400) @(posedge clk);
		flush();
		remote_u.send(9'h05A, 8, 0, 1, 16, 1, 0);
		rchk(`UFMC_OFF_RXD, 32'h0000_805A);
		repeat (200) @(posedge clk);
		rd(`UFMC_OFF_STAT, d, r);
		`CHK(d[0], 1'b0)
		w(`UFMC_OFF_MODE, 32'h0000_0000);
		remote_u.idle(0);
		repeat (400) @(posedge clk);
		flush();
		$display("test polarity done");
	endtask
	task automatic t_fast_fifo();
		logic [31:0] d;
		logic [1:0] r;
		w(`UFMC_OFF_MODE, 32'h0000_0008);
		for (int i = 0; i < 8; i++) remote_u.send(9'h010 + i, 8, 0, 1, 4, 0, 0);
		rd(`UFMC_OFF_STAT, d, r);
		`CHK(d[2], 1'b1)
		// a full buffer parks the next character in the receiver and loses the one after
		remote_u.send(9'h099, 8, 0, 1, 4, 0, 0);
		remote_u.send(9'h0AA, 8, 0, 1, 4, 0, 0);
		for (int i = 0; i < 8; i++) rchk(`UFMC_OFF_RXD, 32'h0000_8010 + i);
		rchk(`UFMC_OFF_RXD, 32'h0000_8099);
		rd(`UFMC_OFF_RXD, d, r);
		`CHK(d[15], 1'b0)
		$display("test fast fifo done");
	endtask
	task automatic t_autobaud();
		logic [31:0] d;
		logic [1:0] r;
		w(`UFMC_OFF_MODE, 32'h0000_0028);
		remote_u.send(9'h055, 8, 0, 1, 4, 0, 0);
		rchk(`UFMC_OFF_MODE, 32'h0000_0028);
		rchk(`UFMC_OFF_DIV, 32'h0000_0000);
		flush();
		// 72 cycles a bit keeps the measured count clear of a rounding edge
		w(`UFMC_OFF_MODE, 32'h0000_0020);
		remote_u.send(9'h055, 8, 0, 1, 72, 0, 0);
		rchk(`UFMC_OFF_MODE, 32'h0000_0000);
		rchk(`UFMC_OFF_DIV, 32'h0000_0003);
		rd(`UFMC_OFF_RXD, d, r);
		`CHK(d[15], 1'b0)
		remote_u.send(9'h0C3, 8, 0, 1, 64, 0, 0);
		rchk(`UFMC_OFF_RXD, 32'h0000_80C3);
		$display("test autobaud done");
	endtask
	initial begin
		rst_b = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_rx_formats();
		t_tx();
		t_polarity();
		t_fast_fifo();
		t_autobaud();
		end_of_test();
	end
endmodule

//--- tb/ufmc_remote.sv
`timescale 1ns/1ps
module ufmc_remote (
	input  wire logic clk,
	output logic      line_out,
	input  wire logic line_in
);
	initial line_out = 1'b1;
	// idle level of the wire as the far end sees it
	task automatic idle(input bit inv);
		@(posedge clk) line_out <= !inv;
	endtask
	// bad pulls the last stop bit low to provoke a framing error
	task automatic send(input logic [8:0] d, input int nb, input int pm, input int ns,
		input int per, input bit inv, input bit bad);
		logic b[$];
		b.push_back(1'b0);
		for (int i = 0; i < nb; i++) b.push_back(d[i]);
		if (pm != 0) b.push_back(^d[7:0] ^ (pm == 2));
		for (int i = 0; i < ns; i++) b.push_back(!(bad && i == ns - 1));
		foreach (b[i]) begin
			@(posedge clk) line_out <= b[i] ^ inv;
			repeat (per - 1) @(posedge clk);
		end
		@(posedge clk) line_out <= !inv;
		repeat (2 * per) @(posedge clk);
	endtask
	// samples at mid bit on the falling clock so the line has settled
	task automatic recv(input int nb, input int pm, input int ns, input int per,
		output logic [8:0] d, output logic p, output logic st);
		d = 9'h000;
		p = 1'b0;
		st = 1'b1;
		do @(negedge clk); while (line_in !== 1'b0);
		repeat (per / 2) @(negedge clk);
		for (int i = 0; i < nb; i++) begin
			repeat (per) @(negedge clk);
			d[i] = line_in;
		end
		if (pm != 0) begin
			repeat (per) @(negedge clk);
			p = line_in;
		end
		for (int i = 0; i < ns; i++) begin
			repeat (per) @(negedge clk);
			st = st & line_in;
		end
	endtask
endmodule
